// ---- bench/tick_partner.sv ----
// partner model: clock-management ticks, sub-increment pulses, direction levels
`timescale 1ns/1ps
module tick_partner
	import time_base_pkg::*;
(
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst_b,
	// pacing: high gives dense ticks, low gives sparse ones
	input  wire logic              dense,
	// tick outputs
	output logic     [TICK_N-1:0]  managed_tick,
	output logic     [1:0]         sub_inc_tick,
	output logic     [1:0]         count_down
);
	int seed = 25;
	// ------------------------------------------------------------
	// tick generation
	// ------------------------------------------------------------
	// one-cycle pulses; sparse mode ands three draws so gaps grow long
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			managed_tick <= '0;
			sub_inc_tick <= 2'h0;
			count_down   <= 2'h0;
		end else begin
			managed_tick <= dense ? TICK_N'($random(seed)) :
				TICK_N'($random(seed) & $random(seed) & $random(seed));
			sub_inc_tick <= 2'($random(seed));
			// direction is a level, so it changes only now and then
			if (($random(seed) & 7) == 0) count_down <= 2'($random(seed));
		end
	end
endmodule : tick_partner

// ---- bench/time_base_channels_tb_top.sv ----
// testbench: time base unit against a shadow model with partner ticks
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module time_base_channels_tb_top import time_base_pkg::*; ();
	logic                sys_clk = 1'b0;
	logic                rst_b = 1'b0;
	logic [7:0]          reg_addr = 8'h00;
	logic [31:0]         reg_wdata = 32'h00000000;
	logic                reg_write = 1'b0;
	logic                reg_read = 1'b0;
	logic                dense = 1'b1;
	logic [31:0]         reg_rdata;
	logic [TICK_N-1:0]   managed_tick;
	logic [1:0]          sub_inc_tick;
	logic [1:0]          count_down;
	logic [BASE0_W-1:0]  primary_time_stamp;
	logic [STAMP_W-1:0]  capture_stamp;
	logic [AUX_W-1:0]    aux_time_stamp1;
	logic [AUX_W-1:0]    aux_time_stamp2;
	int                  err_count = 0;
	int                  n_compared = 0;
	int                  seed = 25;
	int                  v[3];
	int                  src[3];
	bit                  en[3];
	bit                  md[3];
	bit                  rd_pend;
	logic [31:0]         rd_exp;

	always #2 sys_clk = ~sys_clk;

	time_base_unit time_base_unit_i (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .managed_tick(managed_tick), .sub_inc_tick(sub_inc_tick),
		.count_down(count_down), .primary_time_stamp(primary_time_stamp),
		.capture_stamp(capture_stamp), .aux_time_stamp1(aux_time_stamp1),
		.aux_time_stamp2(aux_time_stamp2));
	tick_partner tick_partner_i (.sys_clk(sys_clk), .rst_b(rst_b), .dense(dense),
		.managed_tick(managed_tick), .sub_inc_tick(sub_inc_tick), .count_down(count_down));

	// ------------------------------------------------------------
	// shadow model
	// ------------------------------------------------------------
	// control bit 0 is resolution on channel 0 and mode on channels 1, 2
	function automatic logic [31:0] regval(logic [7:0] a);
		int c;
		c = (int'(a) - 4) >>> 3;
		if (a == 8'h00) return {26'h0, {2{en[2]}}, {2{en[1]}}, {2{en[0]}}};
		if (a < 8'h04 || a > 8'h18 || a[1:0] != 2'h0) return 32'h00000000;
		return a[2] ? 32'(src[c] * 2 + md[c]) : 32'(v[c]);
	endfunction : regval

	// enabled channels refuse value and control writes silently
	function automatic void apply(logic [7:0] a, logic [31:0] d);
		int c;
		c = (int'(a) - 4) >>> 3;
		if (a == 8'h00) begin
			for (int k = 0; k < 3; k++) begin
				if (d[2*k +: 2] == 2'h1) en[k] = 1'b0;
				if (d[2*k +: 2] == 2'h2) en[k] = 1'b1;
			end
		end else if (a >= 8'h04 && a <= 8'h18 && a[1:0] == 2'h0 && !en[c]) begin
			if (a[2]) begin
				md[c] = d[0];
				src[c] = int'(d[3:1]);
			end else v[c] = int'(d & (c == 0 ? 32'h07FFFFFF : 32'h00FFFFFF));
		end
	endfunction : apply

	// counts from pre-edge state, then lands the write, as the design does
	always @(posedge sys_clk) begin : shadow
		int c;
		int mask;
		if (!rst_b) begin
			foreach (v[k]) begin
				v[k] = 0;
				src[k] = 0;
				en[k] = 1'b0;
				md[k] = 1'b0;
			end
			rd_pend = 1'b0;
		end else begin
			`CHK(32'(primary_time_stamp), 32'(v[0]))
			`CHK(32'(capture_stamp), 32'(md[0] ? v[0] >> 3 : v[0] & 'hFFFFFF))
			`CHK(32'(aux_time_stamp1), 32'(v[1]))
			`CHK(32'(aux_time_stamp2), 32'(v[2]))
			`CHK(reg_rdata, rd_pend ? rd_exp : 32'h00000000)
			rd_pend = reg_read;
			rd_exp = regval(reg_addr);
			for (c = 0; c < 3; c++) begin
				mask = (c == 0) ? 32'h07FFFFFF : 32'h00FFFFFF;
				if (en[c] && c > 0 && md[c]) begin
					if (sub_inc_tick[c-1]) v[c] = (v[c] + (count_down[c-1] ? -1 : 1)) & mask;
				end else if (en[c] && managed_tick[src[c]]) v[c] = (v[c] + 1) & mask;
			end
			if (reg_write) apply(reg_addr, reg_wdata);
		end
	end

	// ------------------------------------------------------------
	// bus tasks and closing
	// ------------------------------------------------------------
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge sys_clk);
		reg_write <= 1'b0;
	endtask : wr

	// whole map plus two unmapped words; the shadow checks each answer
	task automatic rd_all();
		for (int a = 0; a <= 32; a += 4) begin
			@(posedge sys_clk);
			reg_addr <= 8'(a);
			reg_read <= 1'b1;
			@(posedge sys_clk);
			reg_read <= 1'b0;
		end
	endtask : rd_all

	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : summarize

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin : main
		logic [31:0] r;
		repeat (16) @(posedge sys_clk);
		rst_b <= 1'b1;
		rd_all();
		wr(8'h1C, 32'hFFFFFFFF);
		$display("test reset_values done");
		// every source code, both modes, both resolutions, wrap both ways
		for (int i = 0; i < 8; i++) begin
			dense <= i[0];
			wr(8'h00, 32'h00000015);
			wr(8'h04, 32'(i * 2 + ((i >> 1) & 1)));
			wr(8'h0C, 32'(i * 2 + (i & 1)));
			wr(8'h14, 32'((7 - i) * 2 + (~i & 1)));
			for (int c = 0; c < 3; c++) begin
				r = $random(seed);
				wr(8'(8 + 8 * c), i[1] ? ~(r & 32'h0000000F) : (r & 32'h0000000F));
			end
			rd_all();
			wr(8'h00, 32'h0000002A);
			repeat (30) @(posedge sys_clk);
			wr(8'h00, 32'h0000003F);
			// writes to an enabled channel must leave it alone
			for (int a = 4; a <= 24; a += 4) wr(8'(a), $random(seed));
			rd_all();
			wr(8'h00, 32'h00000005);
			repeat (20) @(posedge sys_clk);
			rd_all();
			$display("test pass %0d done", i);
		end
		summarize();
	end

	// generous bound: the sequence needs roughly 1100 cycles
	initial begin : watchdog
		repeat (20000) @(posedge sys_clk);
		err_count++;
		summarize();
	end
endmodule : time_base_channels_tb_top

// ---- design/aux_counter.sv ----
// aux time base channel: 24-bit counter, free running or forward/backward
`timescale 1ns/1ps
module aux_counter
	import time_base_pkg::*;
(
	// clock and reset
	input  wire logic                sys_clk,
	input  wire logic                rst_b,
	// control
	input  wire logic                enable,
	input  wire count_mode_select_t  count_mode_select,
	input  wire logic [SRC_W-1:0]    tick_source_select,
	input  wire logic [TICK_N-1:0]   managed_tick,
	input  wire logic                sub_inc_tick,
	input  wire logic                count_down,
	// software load while disabled
	input  wire logic                load,
	input  wire logic [AUX_W-1:0]    load_value,
	// count
	output logic      [AUX_W-1:0]    count
);
	// ----------------------------------------------------------------
	// step selection
	// ----------------------------------------------------------------
	wire logic             free_step = managed_tick[tick_source_select];
	wire logic             bidir     = (count_mode_select == FORWARD_BACKWARD);
	wire logic             step      = bidir ? sub_inc_tick : free_step;
	wire logic             go_down   = bidir && count_down;
	// wrap falls out of modulo arithmetic in both directions
	wire logic [AUX_W-1:0] next_count = go_down ? count - 1'b1 : count + 1'b1;

	// counter: holds while disabled, loads only then
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= AUX_RESET;
		end else if (!enable) begin
			if (load) begin
				count <= load_value;
			end
		end else if (step) begin
			count <= next_count;
		end
	end

	a_down_step: assert property (@(posedge sys_clk) disable iff (!rst_b)
		enable && bidir && sub_inc_tick && count_down |=> count == $past(count) - 1'b1)
		else $error("aux counter did not decrement");
	a_disabled_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!enable && !load |=> count == $past(count))
		else $error("disabled aux counter moved");
endmodule : aux_counter

// ---- design/time_base_pkg.sv ----
// package: register map, field layout and constants of the time base unit
package time_base_pkg;
	// ----------------------------------------------------------------
	// register offsets (byte addresses, one aligned word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CHANNEL_ENABLE   = 8'h00;
	localparam logic [7:0] ADDR_BASE0_CONTROL    = 8'h04;
	localparam logic [7:0] ADDR_TIME_BASE0_VALUE = 8'h08;
	localparam logic [7:0] ADDR_AUX1_CONTROL     = 8'h0C;
	localparam logic [7:0] ADDR_AUX1_VALUE       = 8'h10;
	localparam logic [7:0] ADDR_AUX2_CONTROL     = 8'h14;
	localparam logic [7:0] ADDR_AUX2_VALUE       = 8'h18;

	// ----------------------------------------------------------------
	// widths and field positions (lsb-0 numbering)
	// ----------------------------------------------------------------
	localparam int BASE0_W   = 27;
	localparam int AUX_W     = 24;
	localparam int STAMP_W   = 24;
	localparam int SRC_W     = 3;
	localparam int TICK_N    = 8;
	localparam int RES_SHIFT = 3;
	localparam int MODE_BIT  = 0;
	localparam int SRC_LSB   = 1;
	localparam int RES_BIT   = 0;
	localparam int EN0_LSB   = 0;
	localparam int EN1_LSB   = 2;
	localparam int EN2_LSB   = 4;

	// ----------------------------------------------------------------
	// enable pair codes and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] PAIR_DISABLE = 2'h1;
	localparam logic [1:0] PAIR_ENABLE  = 2'h2;
	localparam logic [1:0] PAIR_READ_ON = 2'h3;
	localparam logic [1:0] PAIR_READ_OFF = 2'h0;
	localparam logic [BASE0_W-1:0] BASE0_RESET = 27'h0000000;
	localparam logic [AUX_W-1:0]   AUX_RESET   = 24'h000000;
	localparam logic [SRC_W-1:0]   SRC_RESET   = 3'h0;

	typedef enum logic {
		FREE_RUNNING,
		FORWARD_BACKWARD
	} count_mode_select_t;
endpackage : time_base_pkg

// ---- design/time_base_unit.sv ----
// time base unit: channel 0 27-bit stamp counter and two aux channels
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module time_base_unit
	import time_base_pkg::*;
(
	// clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 rst_b,
	// register port
	input  wire logic [7:0]           reg_addr,
	input  wire logic [31:0]          reg_wdata,
	input  wire logic                 reg_write,
	input  wire logic                 reg_read,
	output logic      [31:0]          reg_rdata,
	// tick sources (same clock domain)
	input  wire logic [TICK_N-1:0]    managed_tick,
	input  wire logic [1:0]           sub_inc_tick,
	input  wire logic [1:0]           count_down,
	// time stamps to the input timers
	output logic      [BASE0_W-1:0]   primary_time_stamp,
	output logic      [STAMP_W-1:0]   capture_stamp,
	output logic      [AUX_W-1:0]     aux_time_stamp1,
	output logic      [AUX_W-1:0]     aux_time_stamp2
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [2:0]               enabled;
	logic                     resolution_select;
	logic [SRC_W-1:0]         src0;
	logic [BASE0_W-1:0]       base0;
	count_mode_select_t       mode [1:2];
	logic [SRC_W-1:0]         src  [1:2];
	logic [AUX_W-1:0]         aux_count [1:2];

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	// next enable for one pair; 00 and 11 keep the present state
	function automatic logic pair_next(input logic [1:0] code, input logic cur);
		pair_next = (code == PAIR_ENABLE) ? 1'b1 : (code == PAIR_DISABLE) ? 1'b0 : cur;
	endfunction : pair_next

	function automatic logic [1:0] pair_read(input logic on);
		pair_read = on ? PAIR_READ_ON : PAIR_READ_OFF;
	endfunction : pair_read

	wire logic wr_enable = reg_write && hit(reg_addr, ADDR_CHANNEL_ENABLE);
	wire logic wr_ctrl0  = reg_write && hit(reg_addr, ADDR_BASE0_CONTROL);
	wire logic wr_base0  = reg_write && hit(reg_addr, ADDR_TIME_BASE0_VALUE);
	wire logic wr_ctrl1  = reg_write && hit(reg_addr, ADDR_AUX1_CONTROL);
	wire logic wr_val1   = reg_write && hit(reg_addr, ADDR_AUX1_VALUE);
	wire logic wr_ctrl2  = reg_write && hit(reg_addr, ADDR_AUX2_CONTROL);
	wire logic wr_val2   = reg_write && hit(reg_addr, ADDR_AUX2_VALUE);
	wire logic [2:0] wr_ctrl = {wr_ctrl2, wr_ctrl1, 1'b0};
	wire logic [2:0] wr_val  = {wr_val2, wr_val1, 1'b0};

	wire logic [1:0] code0 = reg_wdata[EN0_LSB +: 2];
	wire logic [1:0] code1 = reg_wdata[EN1_LSB +: 2];
	wire logic [1:0] code2 = reg_wdata[EN2_LSB +: 2];
	wire logic [2:0] next_enabled = {pair_next(code2, enabled[2]),
	                                 pair_next(code1, enabled[1]),
	                                 pair_next(code0, enabled[0])};

	// ----------------------------------------------------------------
	// channel enables
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			enabled <= 3'h0;
		end else if (wr_enable) begin
			enabled <= next_enabled;
		end
	end

	// ----------------------------------------------------------------
	// channel 0 control and counter
	// ----------------------------------------------------------------
	wire logic               tick0      = managed_tick[src0];
	wire logic [BASE0_W-1:0] next_base0 = base0 + 1'b1;

	// settings frozen while running so stamps stay consistent
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			resolution_select <= 1'b0;
			src0              <= SRC_RESET;
		end else if (wr_ctrl0 && !enabled[0]) begin
			resolution_select <= reg_wdata[RES_BIT];
			src0              <= reg_wdata[SRC_LSB +: SRC_W];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			base0 <= BASE0_RESET;
		end else if (!enabled[0]) begin
			if (wr_base0) begin
				base0 <= reg_wdata[BASE0_W-1:0];
			end
		end else if (tick0) begin
			base0 <= next_base0;
		end
	end

	// ----------------------------------------------------------------
	// aux channels 1 and 2
	// ----------------------------------------------------------------
	generate
		for (genvar ch = 1; ch <= 2; ch++) begin : g_aux
			// mode and source ignore writes while the channel runs
			always_ff @(posedge sys_clk or negedge rst_b) begin
				if (!rst_b) begin
					mode[ch] <= FREE_RUNNING;
					src[ch]  <= SRC_RESET;
				end else if (wr_ctrl[ch] && !enabled[ch]) begin
					mode[ch] <= count_mode_select_t'(reg_wdata[MODE_BIT]);
					src[ch]  <= reg_wdata[SRC_LSB +: SRC_W];
				end
			end

			aux_counter u_aux (
				.sys_clk            (sys_clk),
				.rst_b              (rst_b),
				.enable             (enabled[ch]),
				.count_mode_select  (mode[ch]),
				.tick_source_select (src[ch]),
				.managed_tick       (managed_tick),
				.sub_inc_tick       (sub_inc_tick[ch-1]),
				.count_down         (count_down[ch-1]),
				.load               (wr_val[ch]),
				.load_value         (reg_wdata[AUX_W-1:0]),
				.count              (aux_count[ch])
			);

			a_mode_frozen: assert property (@(posedge sys_clk) disable iff (!rst_b)
				enabled[ch] && $past(enabled[ch]) |-> $stable(mode[ch]) && $stable(src[ch]))
				else $error("aux setting changed while enabled");
		end
	endgenerate

	// ----------------------------------------------------------------
	// time stamp outputs
	// ----------------------------------------------------------------
	assign primary_time_stamp = base0;
	assign capture_stamp      = resolution_select ?
	                            base0[RES_SHIFT +: STAMP_W] : base0[STAMP_W-1:0];
	assign aux_time_stamp1    = aux_count[1];
	assign aux_time_stamp2    = aux_count[2];

	// ----------------------------------------------------------------
	// read mux; unmapped addresses read zero
	// ----------------------------------------------------------------
	logic [31:0] read_mux;
	always_comb begin
		read_mux = 32'h0000_0000;
		unique case (1'b1)
			hit(reg_addr, ADDR_CHANNEL_ENABLE): begin
				read_mux[EN0_LSB +: 2] = pair_read(enabled[0]);
				read_mux[EN1_LSB +: 2] = pair_read(enabled[1]);
				read_mux[EN2_LSB +: 2] = pair_read(enabled[2]);
			end
			hit(reg_addr, ADDR_BASE0_CONTROL): begin
				read_mux[RES_BIT]             = resolution_select;
				read_mux[SRC_LSB +: SRC_W]    = src0;
			end
			hit(reg_addr, ADDR_TIME_BASE0_VALUE): read_mux[BASE0_W-1:0] = base0;
			hit(reg_addr, ADDR_AUX1_CONTROL): begin
				read_mux[MODE_BIT]            = mode[1];
				read_mux[SRC_LSB +: SRC_W]    = src[1];
			end
			hit(reg_addr, ADDR_AUX1_VALUE): read_mux[AUX_W-1:0] = aux_count[1];
			hit(reg_addr, ADDR_AUX2_CONTROL): begin
				read_mux[MODE_BIT]            = mode[2];
				read_mux[SRC_LSB +: SRC_W]    = src[2];
			end
			hit(reg_addr, ADDR_AUX2_VALUE): read_mux[AUX_W-1:0] = aux_count[2];
			default: read_mux = 32'h0000_0000;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			reg_rdata <= reg_read ? read_mux : 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_base0_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
		wr_base0 && !enabled[0] |=> base0 == $past(reg_wdata[BASE0_W-1:0]))
		else $error("channel 0 load lost");
	a_base0_count: assert property (@(posedge sys_clk) disable iff (!rst_b)
		enabled[0] && tick0 |=> base0 == $past(base0) + 1'b1)
		else $error("channel 0 did not advance");
	a_base0_live: assert property (@(posedge sys_clk) disable iff (!rst_b)
		reg_read && hit(reg_addr, ADDR_TIME_BASE0_VALUE)
		|=> reg_rdata == {5'h00, $past(base0)})
		else $error("channel 0 read not live");
	a_aux_read: assert property (@(posedge sys_clk) disable iff (!rst_b)
		reg_read && hit(reg_addr, ADDR_AUX1_VALUE)
		|=> reg_rdata == {8'h00, $past(aux_count[1])})
		else $error("aux 1 read wrong");
	a_pair_enable: assert property (@(posedge sys_clk) disable iff (!rst_b)
		wr_enable && code0 == PAIR_ENABLE |=> enabled[0] ##1 enabled[0] || wr_enable)
		else $error("enable code not taken");
	a_pair_keep: assert property (@(posedge sys_clk) disable iff (!rst_b)
		wr_enable && (code1 == 2'h0 || code1 == 2'h3) |=> $stable(enabled[1]))
		else $error("keep code changed enable");
	a_stamp_select: assert property (@(posedge sys_clk) disable iff (!rst_b)
		resolution_select |-> capture_stamp == base0[26:3])
		else $error("upper stamp bits wrong");
	a_ctrl_reserved: assert property (@(posedge sys_clk) disable iff (!rst_b)
		reg_read && hit(reg_addr, ADDR_AUX2_CONTROL) |=> reg_rdata[31:4] == 28'h0)
		else $error("reserved control bits set");

	// ----------------------------------------------------------------
	// refusals, read-back layout and counting steps
	// ----------------------------------------------------------------
	a_base0_frozen: assert property (@(posedge sys_clk) disable iff (!rst_b)
		wr_base0 && enabled[0] && !tick0 |=> $stable(base0))
		else $error("channel 0 value written while enabled");
	a_value0_reserved: assert property (@(posedge sys_clk) disable iff (!rst_b)
		reg_read && hit(reg_addr, ADDR_TIME_BASE0_VALUE) |=> reg_rdata[31:BASE0_W] == '0)
		else $error("channel 0 reserved bits set");
	a_aux_reserved: assert property (@(posedge sys_clk) disable iff (!rst_b)
		reg_read && hit(reg_addr, ADDR_AUX1_VALUE) |=> reg_rdata[31:AUX_W] == '0)
		else $error("aux value reserved bits set");
	a_enable_reserved: assert property (@(posedge sys_clk) disable iff (!rst_b)
		reg_read && hit(reg_addr, ADDR_CHANNEL_ENABLE) |=> reg_rdata[31:6] == '0)
		else $error("enable reserved bits set");
	a_rdata_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!reg_read |=> reg_rdata == 32'h0000_0000)
		else $error("read data without a read");
	a_enable_readback: assert property (@(posedge sys_clk) disable iff (!rst_b)
		reg_read && hit(reg_addr, ADDR_CHANNEL_ENABLE)
		|=> reg_rdata[EN0_LSB +: 2] == {2{$past(enabled[0])}})
		else $error("enable pair read back wrong");
	a_pair_disable: assert property (@(posedge sys_clk) disable iff (!rst_b)
		wr_enable && code2 == PAIR_DISABLE |=> !enabled[2])
		else $error("disable code not taken");
	a_pair_hold0: assert property (@(posedge sys_clk) disable iff (!rst_b)
		wr_enable && (code0 == 2'h0 || code0 == 2'h3) |=> $stable(enabled[0]))
		else $error("keep code changed channel 0");
	a_mode_refused: assert property (@(posedge sys_clk) disable iff (!rst_b)
		wr_ctrl1 && enabled[1] |=> $stable(mode[1]))
		else $error("mode written while enabled");
	a_source_refused: assert property (@(posedge sys_clk) disable iff (!rst_b)
		wr_ctrl2 && enabled[2] |=> $stable(src[2]))
		else $error("source written while enabled");
	a_aux_load: assert property (@(posedge sys_clk) disable iff (!rst_b)
		wr_val1 && !enabled[1] |=> aux_count[1] == $past(reg_wdata[AUX_W-1:0]))
		else $error("aux 1 load lost");
	a_mode_readback: assert property (@(posedge sys_clk) disable iff (!rst_b)
		reg_read && hit(reg_addr, ADDR_AUX1_CONTROL) |=> reg_rdata[MODE_BIT] == $past(mode[1]))
		else $error("mode read back wrong");
	a_source_readback: assert property (@(posedge sys_clk) disable iff (!rst_b)
		reg_read && hit(reg_addr, ADDR_AUX2_CONTROL)
		|=> reg_rdata[SRC_LSB +: SRC_W] == $past(src[2]))
		else $error("source read back wrong");
	a_aux2_read: assert property (@(posedge sys_clk) disable iff (!rst_b)
		reg_read && hit(reg_addr, ADDR_AUX2_VALUE)
		|=> reg_rdata == {8'h00, $past(aux_count[2])})
		else $error("aux 2 read wrong");
	a_stamp_lower: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!resolution_select |-> capture_stamp == base0[STAMP_W-1:0])
		else $error("lower stamp bits wrong");
	a_stamps_routed: assert property (@(posedge sys_clk) disable iff (!rst_b)
		primary_time_stamp == base0 && aux_time_stamp1 == aux_count[1]
		&& aux_time_stamp2 == aux_count[2])
		else $error("time stamp not routed");
	a_base0_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!enabled[0] && !wr_base0 |=> $stable(base0))
		else $error("disabled channel 0 moved");
	a_base0_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
		enabled[0] && !tick0 |=> $stable(base0))
		else $error("channel 0 moved without tick");
	a_free_step: assert property (@(posedge sys_clk) disable iff (!rst_b)
		enabled[1] && mode[1] == FREE_RUNNING && managed_tick[src[1]]
		|=> aux_count[1] == $past(aux_count[1]) + 1'b1)
		else $error("aux 1 free step missed");
	a_up_step: assert property (@(posedge sys_clk) disable iff (!rst_b)
		enabled[1] && mode[1] == FORWARD_BACKWARD && sub_inc_tick[0] && !count_down[0]
		|=> aux_count[1] == $past(aux_count[1]) + 1'b1)
		else $error("aux 1 up step missed");
endmodule : time_base_unit
